// *** rtl/acq_defines.svh ***
// Offsets, field positions and reset values of the acquisition control registers
`ifndef ACQ_DEFINES_SVH
`define ACQ_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_CTRL 7'h00
`define OFS_RATE 7'h14
`define OFS_DIV01 7'h18
`define OFS_DIV23 7'h1c
`define OFS_DIV45 7'h20
`define OFS_THR 7'h38
`define OFS_REV 7'h3c
`define OFS_SIZE 7'h40
`define OFS_DATA 7'h48

// ----------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------
`define RST_CTRL 32'h0000383c
`define RST_RATE 8'h10
`define RST_DIV 14'h0505
`define RST_THR 16'hfffe
`define CTRL_RW_MASK 32'h000307ff

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTRL_EVT_LO 8
`define CTRL_EVT_HI 10
`define CTRL_IRQ 11
`define CTRL_PASS 12
`define CTRL_READY 13
`define CTRL_THR 14
`define CTRL_LOCK 16
`define THR_DIS 18
`define THR_FLUSH 19
`define REV_DMA 15
`define REV_4CH 16
`define REV_2CH 17
`define SRC_CODE_EXT 4'h4
`define SRC_CODE_OFF 4'h5

`endif

// *** rtl/acq_pkg.sv ***
// Types shared by the acquisition control registers
package acq_pkg;
    typedef enum logic [1:0] {SRC_GEN_A, SRC_GEN_B, SRC_EXT, SRC_OFF} clk_src_e;
    typedef enum logic [2:0] {
        EVT_INIT, EVT_CAL, EVT_READY, EVT_THR_RISE,
        EVT_THR_FALL, EVT_AEMPTY, EVT_AFULL, EVT_RSVD
    } irq_evt_e;
    typedef enum logic {SCAN_IDLE, SCAN_RUN} scan_state_e;
endpackage

// *** rtl/sample_store.sv ***
// Input data buffer: a flushable FIFO with a sample count
`timescale 1ns/1ps
module sample_store #(
    parameter int W = 19,
    parameter int DEPTH = 256
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic flush_i,
    input wire logic wr_i,
    input wire logic [W-1:0] wdata_i,
    input wire logic rd_i,
    output logic [W-1:0] rdata_o,
    output logic full_o,
    output logic empty_o,
    output logic [$clog2(DEPTH):0] count_o
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_r;
    logic [AW-1:0] rptr_r;
    logic [AW:0] cnt_r;
    wire do_wr = wr_i && !full_o;
    wire do_rd = rd_i && !empty_o;

    assign full_o = (cnt_r == (AW+1)'(DEPTH));
    assign empty_o = (cnt_r == '0);
    assign count_o = cnt_r;
    assign rdata_o = mem[rptr_r];

    always_ff @(posedge clk_i) begin
        if (do_wr && !flush_i) begin
            mem[wptr_r] <= wdata_i;
        end
    end

    // Flush beats any write or read in the same cycle
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r <= '0;
        end else if (flush_i) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r <= '0;
        end else begin
            if (do_wr) begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (do_rd) begin
                rptr_r <= rptr_r + 1'b1;
            end
            if (do_wr && !do_rd) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (do_rd && !do_wr) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

// *** rtl/acq_regs.sv ***
// Acquisition control registers, scan sequencer and input buffer control
`timescale 1ns/1ps
`include "acq_defines.svh"

// Operation
// RULE1 - While buffer input is disabled no sample is written to the buffer.
// RULE2 - Setting the flush bit empties the buffer and zeroes its count.
// RULE3 - Rate assignment holds group 0 code in 3:0, group 1 in 7:4, upper bits read 0, reset 0x10.
// RULE4 - Code 0 picks generator A, 1 generator B, 4 the external clock, others disable the group.
// RULE5 - Each divisor register holds even channel in 5:0, odd in 13:8, reset 0x0505.
// RULE6 - Event codes 0, 1, 2 request on init done, calibration done and channels ready.
// RULE7 - Event codes 3 and 4 request on a rising or falling edge of the threshold flag.
// RULE8 - Event codes 5 and 6 request on transfer buffer almost empty or almost full.
// RULE9 - Lockstep scans store channels 0 upward; otherwise the start rotates per event.
// RULE10 - Revision bit 15 is high when demand-mode DMA is available as well.
// RULE11 - Revision bit 16 marks a four-channel build, bit 17 two channels, 11:0 firmware.
// RULE12 - The host reads the buffer from the fixed data address without incrementing.
// RULE13 - The threshold flag is high while the stored count exceeds the threshold.
// RULE14 - Each buffered word holds the channel tag in 18:16 and the sample in 15:0.
// RULE15 - The selected event sets the request bit and a bus write of zero clears it.
// RULE16 - The flush bit clears itself once the buffer is empty.
module acq_regs #(
    parameter int NCH = 6,
    parameter int DEPTH = 256,
    parameter logic CAP_DEMAND_DMA = 1'b1,
    parameter logic [11:0] FW_REV = 12'h001 // Arbitrary value
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    input wire logic init_done_i,
    input wire logic cal_done_i,
    input wire logic cal_pass_i,
    input wire logic chan_ready_i,
    input wire logic xfer_aempty_i,
    input wire logic xfer_afull_i,
    input wire logic smp_event_i,
    input wire logic [NCH*16-1:0] smp_data_i,
    output logic scan_busy_o,
    output logic irq_o,
    output logic lockstep_o,
    output acq_pkg::clk_src_e grp0_src_o,
    output acq_pkg::clk_src_e grp1_src_o,
    output logic [35:0] div_o
);
    import acq_pkg::*;

    localparam int CW = $clog2(DEPTH) + 1;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire wr_ctrl = reg_wr_i && reg_addr_i == `OFS_CTRL;
    wire wr_rate = reg_wr_i && reg_addr_i == `OFS_RATE;
    wire wr_thr = reg_wr_i && reg_addr_i == `OFS_THR;
    wire [2:0] wr_div;
    assign wr_div[0] = reg_wr_i && reg_addr_i == `OFS_DIV01;
    assign wr_div[1] = reg_wr_i && reg_addr_i == `OFS_DIV23;
    assign wr_div[2] = reg_wr_i && reg_addr_i == `OFS_DIV45;
    wire rd_data = reg_rd_i && reg_addr_i == `OFS_DATA;

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [31:0] ctrl_r;
    logic irq_flag_r;
    logic irq_flag_nxt;
    logic [7:0] rate_r;
    logic [13:0] div_r [3];
    logic [15:0] thr_r;
    logic dis_r;
    logic flush_r;
    logic thr_q_r;
    logic aempty_q_r;
    logic afull_q_r;
    logic ready_q_r;

    wire [2:0] evt_sel = ctrl_r[`CTRL_EVT_HI:`CTRL_EVT_LO];
    wire lockstep = ctrl_r[`CTRL_LOCK];

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_r <= `RST_CTRL & `CTRL_RW_MASK;
            rate_r <= `RST_RATE; // RULE3
            thr_r <= `RST_THR;
            dis_r <= 1'b0;
            flush_r <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= reg_wdata_i & `CTRL_RW_MASK;
            end
            if (wr_rate) begin
                rate_r <= reg_wdata_i[7:0]; // RULE3
            end
            if (wr_thr) begin
                thr_r <= reg_wdata_i[15:0];
                dis_r <= reg_wdata_i[`THR_DIS];
            end
            // Flush holds one cycle, the buffer is empty after it
            flush_r <= wr_thr && reg_wdata_i[`THR_FLUSH]; // RULE16
        end
    end

    for (genvar g = 0; g < 3; g++) begin : g_div
        always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                div_r[g] <= `RST_DIV;
            end else if (wr_div[g]) begin
                div_r[g] <= {reg_wdata_i[13:8], 2'b00, reg_wdata_i[5:0]}; // RULE5
            end
        end
        assign div_o[g*12 +: 12] = {div_r[g][13:8], div_r[g][5:0]};
    end

    // ------------------------------------------------------------------
    // Group clock source
    // ------------------------------------------------------------------
    function automatic clk_src_e src_of(input logic [3:0] code);
        clk_src_e s;
        s = SRC_OFF;
        if (code == 4'h0) begin
            s = SRC_GEN_A;
        end else if (code == 4'h1) begin
            s = SRC_GEN_B;
        end else if (code == `SRC_CODE_EXT) begin
            s = SRC_EXT;
        end
        return s;
    endfunction

    assign grp0_src_o = src_of(rate_r[3:0]); // RULE4
    assign grp1_src_o = src_of(rate_r[7:4]); // RULE4
    assign lockstep_o = lockstep;

    // ------------------------------------------------------------------
    // Input buffer
    // ------------------------------------------------------------------
    logic fifo_wr;
    logic [18:0] fifo_wdata;
    logic [18:0] fifo_rdata;
    logic fifo_full;
    logic fifo_empty;
    logic [CW-1:0] fifo_cnt;

    sample_store #(.W(19), .DEPTH(DEPTH)) u_store (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .flush_i(flush_r), // RULE2
        .wr_i(fifo_wr),
        .wdata_i(fifo_wdata),
        .rd_i(rd_data), // RULE12
        .rdata_o(fifo_rdata),
        .full_o(fifo_full),
        .empty_o(fifo_empty),
        .count_o(fifo_cnt)
    );

    wire thr_flag = 32'(fifo_cnt) > 32'(thr_r); // RULE13

    // ------------------------------------------------------------------
    // Scan sequencer
    // ------------------------------------------------------------------
    scan_state_e state_r;
    logic [NCH*16-1:0] lat_r;
    logic [2:0] idx_r;
    logic [2:0] rot_r;
    logic [2:0] left_r;

    wire [2:0] last_ch = 3'(NCH - 1);
    wire [2:0] idx_inc = (idx_r == last_ch) ? 3'h0 : idx_r + 3'h1;
    wire in_grp0 = 32'(idx_r) < NCH / 2;
    wire grp_on = in_grp0 ? (grp0_src_o != SRC_OFF) : (grp1_src_o != SRC_OFF);
    wire start = state_r == SCAN_IDLE && smp_event_i;

    assign fifo_wr = state_r == SCAN_RUN && !dis_r && grp_on && !flush_r; // RULE1
    assign fifo_wdata = {idx_r, lat_r[idx_r*16 +: 16]}; // RULE14
    assign scan_busy_o = state_r == SCAN_RUN;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r <= SCAN_IDLE;
            lat_r <= '0;
            idx_r <= 3'h0;
            rot_r <= 3'h0;
            left_r <= 3'h0;
        end else begin
            case (state_r)
                SCAN_IDLE: begin
                    if (smp_event_i) begin
                        lat_r <= smp_data_i;
                        idx_r <= lockstep ? 3'h0 : rot_r; // RULE9
                        rot_r <= (rot_r == last_ch) ? 3'h0 : rot_r + 3'h1;
                        left_r <= last_ch;
                        state_r <= SCAN_RUN;
                    end
                end
                SCAN_RUN: begin
                    idx_r <= idx_inc;
                    left_r <= left_r - 3'h1;
                    if (left_r == 3'h0) begin
                        state_r <= SCAN_IDLE;
                    end
                end
                default: begin
                    state_r <= SCAN_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Interrupt event selection
    // ------------------------------------------------------------------
    logic evt_hit;

    always_comb begin
        case (irq_evt_e'(evt_sel))
            EVT_INIT: evt_hit = init_done_i; // RULE6
            EVT_CAL: evt_hit = cal_done_i; // RULE6
            EVT_READY: evt_hit = chan_ready_i && !ready_q_r; // RULE6
            EVT_THR_RISE: evt_hit = thr_flag && !thr_q_r; // RULE7
            EVT_THR_FALL: evt_hit = !thr_flag && thr_q_r; // RULE7
            EVT_AEMPTY: evt_hit = xfer_aempty_i && !aempty_q_r; // RULE8
            EVT_AFULL: evt_hit = xfer_afull_i && !afull_q_r; // RULE8
            default: evt_hit = 1'b0;
        endcase
    end

    // New event wins over a clearing write in the same cycle
    assign irq_flag_nxt = evt_hit ||
        (irq_flag_r && !(wr_ctrl && !reg_wdata_i[`CTRL_IRQ])); // RULE15
    assign irq_o = irq_flag_r;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_flag_r <= 1'(`RST_CTRL >> `CTRL_IRQ);
            thr_q_r <= 1'b0;
            aempty_q_r <= 1'b0;
            afull_q_r <= 1'b0;
            ready_q_r <= 1'b0;
        end else begin
            irq_flag_r <= irq_flag_nxt;
            thr_q_r <= thr_flag;
            aempty_q_r <= xfer_aempty_i;
            afull_q_r <= xfer_afull_i;
            ready_q_r <= chan_ready_i;
        end
    end

    // ------------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------------
    wire [31:0] ctrl_view = ctrl_r | (32'(irq_flag_r) << `CTRL_IRQ) |
        (32'(cal_pass_i) << `CTRL_PASS) | (32'(chan_ready_i) << `CTRL_READY) |
        (32'(thr_flag) << `CTRL_THR); // RULE13
    wire [31:0] rev_view = {14'h0, NCH == 2, NCH == 4, CAP_DEMAND_DMA, 3'h0, FW_REV}; // RULE11
    wire [31:0] thr_view = {12'h0, flush_r, dis_r, 2'b00, thr_r};
    wire sel_div = reg_addr_i == `OFS_DIV01 || reg_addr_i == `OFS_DIV23 ||
        reg_addr_i == `OFS_DIV45;
    wire [1:0] div_ix = reg_addr_i == `OFS_DIV01 ? 2'd0 :
        (reg_addr_i == `OFS_DIV23 ? 2'd1 : 2'd2);
    wire [31:0] rd_mux =
        reg_addr_i == `OFS_CTRL ? ctrl_view :
        reg_addr_i == `OFS_RATE ? {24'h0, rate_r} : // RULE3
        sel_div ? {18'h0, div_r[div_ix]} : // RULE5
        reg_addr_i == `OFS_THR ? thr_view :
        reg_addr_i == `OFS_REV ? rev_view : // RULE10
        reg_addr_i == `OFS_SIZE ? 32'(fifo_cnt) :
        reg_addr_i == `OFS_DATA ? (fifo_empty ? 32'h0 : {13'h0, fifo_rdata}) :
        32'h0;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 32'h0;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    chk_disable_blocks_wr: assert property (dis_r |-> !fifo_wr) // RULE1
        else $error("buffer written while input disabled");
    chk_flush_empties: assert property (flush_r |=> fifo_cnt == '0 && !flush_r) // RULE2
        else $error("flush did not empty buffer or did not clear");
    chk_rate_read_zero: assert property (reg_rd_i && reg_addr_i == `OFS_RATE
        |=> reg_rdata_o[31:8] == 24'h0 && reg_rdata_o[7:0] == $past(rate_r)) // RULE3
        else $error("rate assignment read back wrong");
    chk_group_disable: assert property (rate_r[3:0] >= `SRC_CODE_OFF
        || rate_r[3:0] == 4'h2 |-> grp0_src_o == SRC_OFF) // RULE4
        else $error("group 0 not disabled by its code");
    chk_div_reserved: assert property (reg_rd_i && sel_div
        |=> reg_rdata_o[7:6] == 2'b00 && reg_rdata_o[31:14] == 18'h0) // RULE5
        else $error("divisor reserved bits not zero");
    chk_cal_event: assert property (evt_sel == 3'd1 && cal_done_i |=> irq_o) // RULE6
        else $error("calibration event lost");
    chk_thr_rise: assert property (evt_sel == 3'd3 && $rose(thr_flag) |=> irq_o) // RULE7
        else $error("threshold rise did not request");
    chk_afull_event: assert property (evt_sel == 3'd6 && $rose(xfer_afull_i) |=> irq_o) // RULE8
        else $error("almost full did not request");
    chk_lockstep_start: assert property (start && lockstep |=> idx_r == 3'h0) // RULE9
        else $error("lockstep scan not started at channel 0");
    chk_rev_bits: assert property (reg_rd_i && reg_addr_i == `OFS_REV
        |=> reg_rdata_o[15] == CAP_DEMAND_DMA && reg_rdata_o[16] == (NCH == 4)) // RULE10
        else $error("revision capability bits wrong");
    // First word of a lockstep scan carries tag 0 and channel 0's sample as taken
    chk_tag_matches: assert property (start && lockstep
        |=> fifo_wdata == {3'h0, $past(smp_data_i[15:0])}) // RULE14
        else $error("channel tag mismatch");
    chk_irq_holds: assert property (irq_o && !wr_ctrl |=> irq_o [*1]) // RULE15
        else $error("request dropped without a clear");
endmodule

// *** bench/host_bridge_model.sv ***
// Host-side model: register accesses and a DMA drain of the data port
`timescale 1ns/1ps
module host_bridge_model (
    input wire logic clk_i,
    output logic [6:0] reg_addr_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [31:0] reg_wdata_o,
    input wire logic [31:0] reg_rdata_i
);
    localparam logic [6:0] DMA_LOCAL_ADDR = 7'h48;
    logic [31:0] dma_buf [6];
    initial begin
        reg_addr_o = 7'h7c;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_wdata_o = 32'h0;
    end
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        @(negedge clk_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(negedge clk_i);
        reg_wr_o = 1'b0;
        // Released data shows a changed pattern, not the last value
        reg_wdata_o = ~d;
    endtask
    task automatic rd(input logic [6:0] a, output logic [31:0] d);
        @(negedge clk_i);
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(negedge clk_i);
        reg_rd_o = 1'b0;
        @(negedge clk_i);
        d = reg_rdata_i;
    endtask
    // Drain words from one fixed local address, never incremented
    task automatic dma(input int n);
        for (int i = 0; i < n; i++) begin
            rd(DMA_LOCAL_ADDR, dma_buf[i]);
        end
    endtask
endmodule

// *** bench/tb_acq_regs.sv ***
// Self-checking testbench of the acquisition control registers
`timescale 1ns/1ps
module tb_acq_regs;
    import acq_pkg::*;
    logic clk_i, nrst_i, reg_wr, reg_rd, init_done, cal_done, cal_pass, chan_ready;
    logic aempty, afull, smp_event, scan_busy, irq, lockstep;
    logic [6:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rv;
    logic [95:0] smp_data;
    logic [35:0] div;
    clk_src_e grp0, grp1;
    int fails = 0;
    int total_checks = 0;
    int nev = 0;
    localparam logic [31:0] CTRL = 32'h0000003c;
    localparam logic [31:0] LOCK = 32'h00010000;

    acq_regs i_acq_regs (.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata),
        .reg_rdata_o(reg_rdata), .init_done_i(init_done), .cal_done_i(cal_done),
        .cal_pass_i(cal_pass), .chan_ready_i(chan_ready), .xfer_aempty_i(aempty),
        .xfer_afull_i(afull), .smp_event_i(smp_event), .smp_data_i(smp_data),
        .scan_busy_o(scan_busy), .irq_o(irq), .lockstep_o(lockstep),
        .grp0_src_o(grp0), .grp1_src_o(grp1), .div_o(div));
    host_bridge_model i_host_bridge_model (.clk_i(clk_i), .reg_addr_o(reg_addr),
        .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata),
        .reg_rdata_i(reg_rdata));

    // ----------------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [31:0] exp);
        i_host_bridge_model.rd(a, rv);
        check(rv, exp);
    endtask
    task automatic scan();
        @(negedge clk_i);
        smp_event = 1'b1;
        @(negedge clk_i);
        smp_event = 1'b0;
        nev++;
        check({31'h0, scan_busy}, 32'h1);
        for (int i = 0; i < 20 && scan_busy !== 1'b0; i++) begin
            @(negedge clk_i);
        end
        @(negedge clk_i);
    endtask
    task automatic drain_chk(input int first);
        int ch;
        i_host_bridge_model.dma(6);
        for (int i = 0; i < 6; i++) begin
            ch = (first + i) % 6;
            check(i_host_bridge_model.dma_buf[i], {13'h0, ch[2:0], 16'hc300 + ch[15:0]});
        end
    endtask

    // ----------------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------------
    task automatic t_reset();
        check({31'h0, irq}, 32'h1);
        rd_chk(7'h00, 32'h0000383c);
        rd_chk(7'h14, 32'h00000010);
        for (int a = 0; a < 3; a++) begin
            rd_chk(7'h18 + 7'(a * 4), 32'h00000505);
        end
        rd_chk(7'h3c, 32'h00008001);
        rd_chk(7'h24, 32'h0);
    endtask
    task automatic t_rate();
        clk_src_e exp;
        for (int c = 0; c < 16; c++) begin
            i_host_bridge_model.wr(7'h14, 32'hffffff40 | c);
            exp = (c == 0) ? SRC_GEN_A : (c == 1) ? SRC_GEN_B : (c == 4) ? SRC_EXT : SRC_OFF;
            check({30'h0, grp0}, {30'h0, exp});
        end
        check({30'h0, grp1}, {30'h0, SRC_EXT});
        rd_chk(7'h14, 32'h0000004f);
        i_host_bridge_model.wr(7'h14, 32'h10);
    endtask
    task automatic t_div();
        i_host_bridge_model.wr(7'h1c, 32'hffffffff);
        rd_chk(7'h1c, 32'h00003f3f);
        check({20'h0, div[23:12]}, 32'h00000fff);
        check({20'h0, div[11:0]}, 32'h00000145);
    endtask
    task automatic t_events();
        chan_ready = 1'b0;
        for (int c = 0; c < 8; c++) begin
            if (c == 3 || c == 4) continue;
            i_host_bridge_model.wr(7'h00, CTRL | (c << 8));
            check({31'h0, irq}, 32'h0);
            @(negedge clk_i);
            case (c)
                0: init_done = 1'b1;
                1: cal_done = 1'b1;
                2: chan_ready = 1'b1;
                5: aempty = 1'b1;
                6: afull = 1'b1;
                default: {init_done, cal_done, aempty, afull} = 4'hf;
            endcase
            @(negedge clk_i);
            {init_done, cal_done, aempty, afull} = 4'h0;
            @(negedge clk_i);
            check({31'h0, irq}, {31'h0, c != 7});
        end
    endtask
    task automatic t_scan();
        i_host_bridge_model.wr(7'h38, 32'h2);
        i_host_bridge_model.wr(7'h00, CTRL | LOCK | 32'h300);
        check({31'h0, lockstep}, 32'h1);
        scan();
        check({31'h0, irq}, 32'h1);
        rd_chk(7'h00, CTRL | LOCK | 32'h7b00);
        rd_chk(7'h40, 32'h6);
        i_host_bridge_model.wr(7'h00, CTRL | LOCK | 32'h400);
        check({31'h0, irq}, 32'h0);
        drain_chk(0);
        check({31'h0, irq}, 32'h1);
        i_host_bridge_model.wr(7'h00, CTRL | 32'h700);
        scan();
        drain_chk((nev - 1) % 6);
        rd_chk(7'h48, 32'h0);
    endtask
    task automatic t_gate();
        i_host_bridge_model.wr(7'h38, 32'h0004fffe);
        scan();
        rd_chk(7'h40, 32'h0);
        i_host_bridge_model.wr(7'h38, 32'h0000fffe);
        i_host_bridge_model.wr(7'h14, 32'h15);
        scan();
        rd_chk(7'h40, 32'h3);
        i_host_bridge_model.wr(7'h14, 32'h10);
        scan();
        rd_chk(7'h40, 32'h9);
        i_host_bridge_model.wr(7'h38, 32'h0008fffe);
        rd_chk(7'h40, 32'h0);
        rd_chk(7'h38, 32'h0000fffe);
    endtask

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial begin
        #200us;
        fails++;
        finish_test();
    end
    initial begin
        nrst_i = 1'b0;
        {init_done, cal_done, aempty, afull, smp_event} = 5'h0;
        cal_pass = 1'b1;
        chan_ready = 1'b1;
        for (int n = 0; n < 6; n++) begin
            smp_data[n*16 +: 16] = 16'hc300 + 16'(n);
        end
        repeat (12) @(negedge clk_i);
        nrst_i = 1'b1;
        t_reset();
        t_rate();
        t_div();
        t_events();
        t_scan();
        t_gate();
        finish_test();
    end
endmodule
